// *** common/flash_reg_pkg.sv ***
// Package of constants, types and layouts for the register-access decoder
package flash_reg_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] READ_STATUS_ONE_CMD    = 8'h05;
   localparam logic [7:0] READ_STATUS_TWO_CMD    = 8'h07;
   localparam logic [7:0] READ_CONFIG_CMD        = 8'h35;
   localparam logic [7:0] BANK_READ_CMD          = 8'h16;
   localparam logic [7:0] BANK_WRITE_CMD         = 8'h17;
   localparam logic [7:0] BANK_ACCESS_PREFIX_CMD = 8'hb9;
   localparam logic [7:0] REGISTER_WRITE_CMD     = 8'h01;
   localparam logic [7:0] WRITE_ENABLE_CMD       = 8'h06;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         CR_QUAD_BIT     = 1;
   localparam int         BANK_FOUR_BYTE_ADDRESS_SELECT_BIT = 7;
   localparam logic [7:0] SR1_RESET       = 8'h00;
   localparam logic [7:0] CR_RESET        = 8'h00;
   localparam logic [7:0] BANK_RESET      = 8'h00;

   // Serial frame lengths in SCK rising edges, opcode included
   localparam logic [4:0] BITS_OPCODE_ONLY = 5'h08;
   localparam logic [4:0] BITS_ONE_DATA    = 5'h10;
   localparam logic [4:0] BITS_TWO_DATA    = 5'h18;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 10;
   localparam int REG_WRITE_TIME_NS = 10000;
   localparam int REG_WRITE_CYCLES  = REG_WRITE_TIME_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       status_write_disable;
      logic       program_error;
      logic       erase_error;
      logic [2:0] block_protect_bits;
      logic       write_enable_latch;
      logic       write_in_progress;
   } sr1_t;

   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_RD_SR1,
      ST_RD_SR2,
      ST_RD_CR,
      ST_RD_BANK,
      ST_BANK_DATA,
      ST_WRR_DATA,
      ST_OTHER
   } cmd_state_t;

endpackage

// *** core/spi_rx_shifter.sv ***
// Serial input shifter: collects bytes MSB first on SCK rising edges
`timescale 1ns/10ps
module spi_rx_shifter (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       sel_i,
   input  wire logic       shift_i,
   input  wire logic       si_i,
   output logic [7:0]      byte_o,
   output logic            byte_done_o,
   output logic [2:0]      bit_cnt_o,
   output logic [4:0]      bits_o
);

   logic [6:0] part;
   logic [6:0] next_part;
   logic [2:0] next_bit_cnt;
   logic [4:0] next_bits;
   logic [7:0] next_byte;
   logic       next_done;

   // Shift, count bits in byte and in frame (saturating)
   always_comb begin
      next_part    = part;
      next_bit_cnt = bit_cnt_o;
      next_bits    = bits_o;
      next_byte    = byte_o;
      next_done    = 1'b0;
      if (!sel_i) begin
         next_part    = 7'h00;
         next_bit_cnt = 3'h0;
         next_bits    = 5'h00;
      end else if (shift_i) begin
         next_part    = {part[5:0], si_i};
         next_bit_cnt = bit_cnt_o + 3'h1;
         if (bits_o != 5'h1f) begin
            next_bits = bits_o + 5'h01;
         end
         if (bit_cnt_o == 3'h7) begin
            next_byte = {part, si_i};
            next_done = 1'b1;
         end
      end
   end

   // Registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         part        <= 7'h00;
         bit_cnt_o   <= 3'h0;
         bits_o      <= 5'h00;
         byte_o      <= 8'h00;
         byte_done_o <= 1'b0;
      end else begin
         part        <= next_part;
         bit_cnt_o   <= next_bit_cnt;
         bits_o      <= next_bits;
         byte_o      <= next_byte;
         byte_done_o <= next_done;
      end
   end

endmodule

// *** core/reg_write_timer.sv ***
// Self-timed register write duration counter with failure report
`timescale 1ns/10ps
module reg_write_timer #(
   parameter int CYCLES = 1000,
   localparam int W     = $clog2(CYCLES + 1)
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   input  wire logic fail_i,
   output logic      busy_o,
   output logic      done_o,
   output logic      failed_o
);

   logic [W-1:0] count;
   logic [W-1:0] next_count;

   // Load on start, count down to zero
   always_comb begin
      next_count = count;
      if (start_i && count == '0) begin
         next_count = W'(CYCLES);
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // Last busy cycle marks completion
   assign busy_o   = (count != '0);
   assign done_o   = (count == W'(1));
   assign failed_o = done_o & fail_i;

endmodule

// *** core/spi_flash_register_access.sv ***
// Register-access command decoder of a serial flash device
`timescale 1ns/10ps
// Summary of operation
// RULE_01 - Opcode 05h streams status one, allowed even while busy.
// RULE_02 - Opcode 07h streams status two, allowed even while busy.
// RULE_03 - Status byte repeats every eight clocks, sampled fresh each byte.
// RULE_04 - Opcode 35h streams configuration register, repeating, any time.
// RULE_05 - Opcode 16h streams the bank register, repeating every eight clocks.
// RULE_06 - Opcode 17h plus one byte loads bank register, no write enable.
// RULE_07 - Bank bit 7 clear: upper address bits come from bank register.
// RULE_08 - Bank write leaves program error, erase error and busy untouched.
// RULE_09 - Host writes zero to reserved bank bits.
// RULE_10 - Prefix B9h then register write loads bank bits 1:0 only.
// RULE_11 - After prefixed write, bank access closes; bit 7 kept.
// RULE_12 - Any other command or select cycle after prefix closes access.
// RULE_13 - Prefixed write only legal when idle and no error flag set.
// RULE_14 - Register write accepted only with write enable latch set.
// RULE_15 - Failed self-timed register write sets an error flag.
// RULE_16 - Host writes zero to reserved status and configuration bits.
// RULE_17 - Write executes only on 8 or 16 data bits; 8 writes status only.
// RULE_18 - Host uses 16-bit write format when quad bit is set.
// RULE_19 - Select rise starts timed write; busy bit high meanwhile.
// RULE_20 - Write enable latch clears when the timed write finishes.
// RULE_21 - Status write disable clear: writes allowed whatever protect pin.
// RULE_22 - Disable bit set and protect pin low rejects register writes.
// RULE_23 - Quad bit set disables protect pin hardware protection.
// RULE_24 - Opcode 06h sets the write enable latch, status one bit 1.
// RULE_25 - Input sampled on SCK rise MSB first; output driven on SCK fall.
module spi_flash_register_access #(
   parameter int WRITE_CYCLES = flash_reg_pkg::REG_WRITE_CYCLES
) (
   input  wire logic              REF_CLK_I,
   input  wire logic              RESET_I,
   input  wire logic              SCK_I,
   input  wire logic              CS_N_I,
   input  wire logic              SI_I,
   input  wire logic              WP_N_I,
   input  wire logic              EMBED_BUSY_I,
   input  wire logic              WRITE_FAIL_I,
   input  wire logic [7:0]        STATUS_TWO_I,
   output logic                   SO_O,
   output logic                   SO_OE_O,
   output flash_reg_pkg::sr1_t    STATUS_ONE_O,
   output logic [7:0]             CONFIG_O,
   output logic [7:0]             BANK_O,
   output logic                   FOUR_BYTE_MODE_O,
   output logic [6:0]             UPPER_ADDR_O
);
   import flash_reg_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic       sck_q;
   logic       cs_q;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;
   logic [7:0] rx_byte;
   logic       rx_done;
   logic [2:0] bit_cnt;
   logic [4:0] frame_bits;
   logic       wr_busy;
   logic       wr_done;
   logic       wr_failed;
   logic       wr_start;

   cmd_state_t state;
   cmd_state_t next_state;
   logic [7:0] cmd;
   logic [7:0] next_cmd;
   logic [7:0] data0;
   logic [7:0] next_data0;
   logic [7:0] data1;
   logic [7:0] next_data1;
   logic       bank_open;
   logic       next_bank_open;
   logic [7:0] bank_address;
   logic [7:0] next_bank_address;
   sr1_t       sr1;
   sr1_t       next_sr1;
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic [7:0] pend_sr1;
   logic [7:0] next_pend_sr1;
   logic [7:0] pend_cfg;
   logic [7:0] next_pend_cfg;
   logic       pend_cfg_en;
   logic       next_pend_cfg_en;
   logic [6:0] sreg;
   logic [6:0] next_sreg;
   logic       so;
   logic       next_so;
   logic       so_oe;
   logic       next_so_oe;

   sr1_t       status_now;
   logic       protect;
   logic       write_enable_cmd_go;
   logic       wrr_len_ok;
   logic       prefix_legal;
   logic [7:0] read_value;

   // ----------------------------------------------------------------
   // Pin edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         sck_q <= 1'b0;
         cs_q  <= 1'b1;
      end else begin
         sck_q <= SCK_I;
         cs_q  <= CS_N_I;
      end
   end

   // SCK edges only count while selected
   assign sck_rise = SCK_I & ~sck_q & ~CS_N_I; // RULE_25
   assign sck_fall = ~SCK_I & sck_q & ~CS_N_I; // RULE_25
   assign cs_rise  = CS_N_I & ~cs_q;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   spi_rx_shifter u_rx (
      .clk_i       (REF_CLK_I),
      .rst_i       (RESET_I),
      .sel_i       (~CS_N_I),
      .shift_i     (sck_rise),
      .si_i        (SI_I),
      .byte_o      (rx_byte),
      .byte_done_o (rx_done),
      .bit_cnt_o   (bit_cnt),
      .bits_o      (frame_bits)
   );

   reg_write_timer #(
      .CYCLES (WRITE_CYCLES)
   ) u_timer (
      .clk_i    (REF_CLK_I),
      .rst_i    (RESET_I),
      .start_i  (wr_start),
      .fail_i   (WRITE_FAIL_I),
      .busy_o   (wr_busy),
      .done_o   (wr_done),
      .failed_o (wr_failed)
   );

   // ----------------------------------------------------------------
   // Status view and write qualification
   // ----------------------------------------------------------------
   always_comb begin
      status_now                   = sr1;
      status_now.write_in_progress = wr_busy | EMBED_BUSY_I; // RULE_19
   end

   // Pin protection, bypassed in quad mode
   assign protect = sr1.status_write_disable & ~WP_N_I
                    & ~cfg[CR_QUAD_BIT]; // RULE_22 RULE_23

   assign write_enable_cmd_go = cs_rise && state == ST_OTHER
                    && cmd == WRITE_ENABLE_CMD
                    && frame_bits == BITS_OPCODE_ONLY; // RULE_24

   // Exactly one or two data bytes
   assign wrr_len_ok = frame_bits == BITS_ONE_DATA
                       || frame_bits == BITS_TWO_DATA; // RULE_17

   assign prefix_legal = ~status_now.write_in_progress
                         & ~sr1.program_error
                         & ~sr1.erase_error; // RULE_13

   // Start the timed write: latch set, not busy, not protected
   assign wr_start = cs_rise && state == ST_WRR_DATA && !bank_open
                     && wrr_len_ok && sr1.write_enable_latch
                     && !status_now.write_in_progress
                     && !protect; // RULE_14 RULE_21 RULE_22

   // Fresh value picked at each byte boundary
   always_comb begin
      case (state)
         ST_RD_SR1:  read_value = status_now; // RULE_01
         ST_RD_SR2:  read_value = STATUS_TWO_I; // RULE_02
         ST_RD_CR:   read_value = cfg; // RULE_04
         ST_RD_BANK: read_value = bank_address; // RULE_05
         default:    read_value = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Command decoder and register file
   // ----------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_cmd          = cmd;
      next_data0        = data0;
      next_data1        = data1;
      next_bank_open    = bank_open;
      next_bank_address = bank_address;
      next_sr1          = sr1;
      next_cfg          = cfg;
      next_pend_sr1     = pend_sr1;
      next_pend_cfg     = pend_cfg;
      next_pend_cfg_en  = pend_cfg_en;
      next_sreg         = sreg;
      next_so           = so;
      next_so_oe        = so_oe;

      // Opcode decode and data byte capture
      if (rx_done) begin
         case (state)
            ST_OPCODE: begin
               next_cmd = rx_byte;
               case (rx_byte)
                  READ_STATUS_ONE_CMD: next_state = ST_RD_SR1;
                  READ_STATUS_TWO_CMD: next_state = ST_RD_SR2;
                  READ_CONFIG_CMD:     next_state = ST_RD_CR;
                  BANK_READ_CMD:       next_state = ST_RD_BANK;
                  BANK_WRITE_CMD:      next_state = ST_BANK_DATA;
                  REGISTER_WRITE_CMD:  next_state = ST_WRR_DATA;
                  default:             next_state = ST_OTHER;
               endcase
            end
            ST_BANK_DATA: begin
               // Direct load, no latch needed, flags untouched
               next_bank_address = rx_byte; // RULE_06 RULE_08
               next_state        = ST_OTHER;
            end
            ST_WRR_DATA: begin
               if (frame_bits == BITS_ONE_DATA) begin
                  next_data0 = rx_byte;
               end else begin
                  next_data1 = rx_byte;
               end
            end
            default: begin
            end
         endcase
      end

      // Read data out on falling SCK, reloaded every byte
      if (sck_fall && (state == ST_RD_SR1 || state == ST_RD_SR2
                       || state == ST_RD_CR || state == ST_RD_BANK)) begin
         if (bit_cnt == 3'h0) begin
            next_so    = read_value[7]; // RULE_03 RULE_25
            next_sreg  = read_value[6:0];
            next_so_oe = 1'b1;
         end else begin
            next_so   = sreg[6];
            next_sreg = {sreg[5:0], 1'b0};
         end
      end

      // Frame end: execute write-type commands
      if (cs_rise) begin
         if (state == ST_WRR_DATA && bank_open) begin
            if (prefix_legal && frame_bits >= BITS_ONE_DATA) begin
               // Only bits 1:0 of the first byte, bit 7 kept
               next_bank_address[1:0] = data0[1:0]; // RULE_10 RULE_11
            end
         end else if (wr_start) begin
            next_pend_sr1    = data0; // RULE_19
            next_pend_cfg    = data1;
            next_pend_cfg_en = (frame_bits == BITS_TWO_DATA); // RULE_17
         end
         // Prefix opens access; any other frame closes it
         next_bank_open = state == ST_OTHER
                          && cmd == BANK_ACCESS_PREFIX_CMD
                          && frame_bits == BITS_OPCODE_ONLY; // RULE_11 RULE_12
      end

      // Commit or fail at end of timed write
      if (wr_done) begin
         if (wr_failed) begin
            next_sr1.program_error = 1'b1; // RULE_15
         end else begin
            next_sr1.status_write_disable = pend_sr1[7];
            next_sr1.block_protect_bits   = pend_sr1[4:2];
            if (pend_cfg_en) begin
               next_cfg = pend_cfg;
            end
         end
         next_sr1.write_enable_latch = 1'b0; // RULE_20
      end
      // Set wins over the completion clear
      if (write_enable_cmd_go) begin
         next_sr1.write_enable_latch = 1'b1; // RULE_24
      end

      // Deselect returns the interface to opcode phase
      if (CS_N_I) begin
         next_state = ST_OPCODE;
         next_so_oe = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         state        <= ST_OPCODE;
         cmd          <= 8'h00;
         data0        <= 8'h00;
         data1        <= 8'h00;
         bank_open    <= 1'b0;
         bank_address <= BANK_RESET;
         sr1          <= SR1_RESET;
         cfg          <= CR_RESET;
         pend_sr1     <= 8'h00;
         pend_cfg     <= 8'h00;
         pend_cfg_en  <= 1'b0;
         sreg         <= 7'h00;
         so           <= 1'b0;
         so_oe        <= 1'b0;
      end else begin
         state        <= next_state;
         cmd          <= next_cmd;
         data0        <= next_data0;
         data1        <= next_data1;
         bank_open    <= next_bank_open;
         bank_address <= next_bank_address;
         sr1          <= next_sr1;
         cfg          <= next_cfg;
         pend_sr1     <= next_pend_sr1;
         pend_cfg     <= next_pend_cfg;
         pend_cfg_en  <= next_pend_cfg_en;
         sreg         <= next_sreg;
         so           <= next_so;
         so_oe        <= next_so_oe;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign SO_O             = so;
   assign SO_OE_O          = so_oe;
   assign STATUS_ONE_O     = status_now;
   assign CONFIG_O         = cfg;
   assign BANK_O           = bank_address;
   assign FOUR_BYTE_MODE_O = bank_address[BANK_FOUR_BYTE_ADDRESS_SELECT_BIT];
   // Upper address from bank register in three-byte mode
   assign UPPER_ADDR_O = bank_address[BANK_FOUR_BYTE_ADDRESS_SELECT_BIT] ? 7'h00
                         : bank_address[6:0]; // RULE_07

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);

   property p_status_fresh;
      sck_fall && state == ST_RD_SR1 && bit_cnt == 3'h0
      |=> SO_O == $past(status_now.status_write_disable) && SO_OE_O;
   endproperty
   a_status_fresh: assert property (p_status_fresh) // RULE_01 RULE_03
      else $error("status one MSB not loaded on byte boundary");

   property p_bank_direct;
      rx_done && state == ST_BANK_DATA && !wr_done
      |=> BANK_O == $past(rx_byte) && STATUS_ONE_O.write_enable_latch
          == $past(sr1.write_enable_latch);
   endproperty
   a_bank_direct: assert property (p_bank_direct) // RULE_06
      else $error("bank write did not load bank register");

   property p_bank_flags;
      rx_done && state == ST_BANK_DATA && !wr_done
      |=> $stable(sr1.program_error) && $stable(sr1.erase_error);
   endproperty
   a_bank_flags: assert property (p_bank_flags) // RULE_08
      else $error("bank write altered error flags");

   property p_prefix_load;
      cs_rise && state == ST_WRR_DATA && bank_open && prefix_legal
      && frame_bits >= BITS_ONE_DATA
      |=> BANK_O[1:0] == $past(data0[1:0])
          && BANK_O[7:2] == $past(bank_address[7:2]) && !bank_open;
   endproperty
   a_prefix_load: assert property (p_prefix_load) // RULE_10 RULE_11
      else $error("prefixed write loaded wrong bank bits");

   property p_access_close;
      cs_rise && !(cmd == BANK_ACCESS_PREFIX_CMD && state == ST_OTHER)
      |=> !bank_open;
   endproperty
   a_access_close: assert property (p_access_close) // RULE_12
      else $error("bank access left open after other frame");

   property p_no_latch_no_write;
      cs_rise && state == ST_WRR_DATA && !bank_open
      && (!sr1.write_enable_latch || protect || !wrr_len_ok)
      |=> !$rose(wr_busy);
   endproperty
   a_no_latch_no_write: assert property (p_no_latch_no_write) // RULE_14
      else $error("register write started without permission");

   property p_busy_during_write;
      wr_start |=> STATUS_ONE_O.write_in_progress [*8];
   endproperty
   a_busy_during_write: assert property (p_busy_during_write) // RULE_19
      else $error("busy bit not set during timed write");

   property p_latch_clear;
      wr_done && !write_enable_cmd_go |=> !STATUS_ONE_O.write_enable_latch;
   endproperty
   a_latch_clear: assert property (p_latch_clear) // RULE_20
      else $error("write enable latch not cleared at write end");

   property p_fail_flag;
      wr_failed |=> STATUS_ONE_O.program_error;
   endproperty
   a_fail_flag: assert property (p_fail_flag) // RULE_15
      else $error("failed register write did not set error flag");

   property p_protect;
      sr1.status_write_disable && !WP_N_I && !cfg[CR_QUAD_BIT]
      && state == ST_WRR_DATA && cs_rise && !bank_open
      |=> !$rose(wr_busy);
   endproperty
   a_protect: assert property (p_protect) // RULE_22
      else $error("protected register write was started");

   property p_write_enable_cmd;
      write_enable_cmd_go |=> STATUS_ONE_O.write_enable_latch;
   endproperty
   a_write_enable_cmd: assert property (p_write_enable_cmd) // RULE_24
      else $error("write enable did not set latch");

   property p_upper_addr;
      !FOUR_BYTE_MODE_O |-> UPPER_ADDR_O == BANK_O[6:0];
   endproperty
   a_upper_addr: assert property (p_upper_addr) // RULE_07
      else $error("upper address not taken from bank register");

endmodule

// *** verif/spi_host_model.sv ***
// Host-side serial master model: select, clock and data in
`timescale 1ns/10ps
module spi_host_model (
   input  wire logic clk_i,
   input  wire logic so_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // One frame of n rises; SO taken just before each rise
   task automatic xfer(input logic [23:0] tx, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      @(negedge clk_i) cs_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_o = tx[23-i];
         repeat (3) @(negedge clk_i);
         rx = {rx[14:0], so_i};
         sck_o = 1'b1;
         repeat (3) @(negedge clk_i);
         sck_o = 1'b0;
      end
      repeat (2) @(negedge clk_i);
      cs_n_o = 1'b1;
      // Idle data line must not keep its last value
      si_o = ~si_o;
      repeat (3) @(negedge clk_i);
   endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench of the register-access decoder
`timescale 1ns/10ps
module tb_top;
   import flash_reg_pkg::*;
   typedef struct {logic [23:0] tx; int n; logic [15:0] e; bit c;} row_t;
   logic        clk = 1'b0, rst = 1'b1, wp_n = 1'b1, ebusy = 1'b0;
   logic        fail = 1'b0, sck, cs_n, si, so, oe, four;
   logic [7:0]  cfg, bank;
   logic [6:0]  upper;
   logic [7:0]  st2 = 8'h5a;
   logic [15:0] rx;
   sr1_t        sr1;
   int          num_errors = 0, check_count = 0;
   // Frames in order, expected read data, compare flag
   row_t rows [21] = '{
      '{24'h170200, 16, 16'h0, 0},
      '{24'h160000, 24, 16'h0202, 1},
      '{24'h060000, 8, 16'h0, 0},
      '{24'h050000, 16, 16'h0002, 1},
      '{24'h011c00, 16, 16'h0, 0},
      '{24'h050000, 16, 16'h001c, 1},
      '{24'h060000, 8, 16'h0, 0},
      '{24'h010002, 24, 16'h0, 0},
      '{24'h350000, 24, 16'h0202, 1},
      '{24'h011c02, 24, 16'h0, 0},
      '{24'h050000, 16, 16'h0000, 1},
      '{24'hb90000, 8, 16'h0, 0},
      '{24'h01ffff, 24, 16'h0, 0},
      '{24'h160000, 16, 16'h0003, 1},
      '{24'h070000, 16, 16'h005a, 1},
      '{24'hb90000, 8, 16'h0, 0},
      '{24'h050000, 16, 16'h0000, 1},
      '{24'h060000, 8, 16'h0, 0},
      '{24'h011c02, 24, 16'h0, 0},
      '{24'h050000, 16, 16'h001c, 1},
      '{24'h160000, 16, 16'h0003, 1}};
   always #5 clk = ~clk;
   spi_host_model host (.clk_i(clk), .so_i(so), .sck_o(sck),
      .cs_n_o(cs_n), .si_o(si));
   spi_flash_register_access #(.WRITE_CYCLES(20)) DUT (.REF_CLK_I(clk),
      .RESET_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si), .WP_N_I(wp_n),
      .EMBED_BUSY_I(ebusy), .WRITE_FAIL_I(fail), .STATUS_TWO_I(st2),
      .SO_O(so), .SO_OE_O(oe), .STATUS_ONE_O(sr1), .CONFIG_O(cfg),
      .BANK_O(bank), .FOUR_BYTE_MODE_O(four), .UPPER_ADDR_O(upper));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Write enable, full register write, then let the timed write end
   task automatic wr(input logic [23:0] tx);
      host.xfer(24'h060000, 8, rx);
      host.xfer(tx, 24, rx);
      repeat (30) @(negedge clk);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard
   initial begin
      #300us;
      num_errors++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check({sr1, cfg}, 16'h0000);
      check({8'h00, bank}, 16'h0000);
      foreach (rows[i]) begin
         host.xfer(rows[i].tx, rows[i].n, rx);
         if (rows[i].c)
            check(rows[i].n == 24 ? rx : rx & 16'h00ff, rows[i].e);
      end
      // Status two changes between the two repeated bytes
      fork
         host.xfer(24'h070000, 24, rx);
         begin
            repeat (70) @(negedge clk);
            st2 = 8'ha5;
         end
      join
      check(rx, 16'h5aa5);
      host.xfer(24'h060000, 8, rx);
      host.xfer(24'h010002, 24, rx);
      check({14'h0, sr1[1:0]}, 16'h0003);
      repeat (30) @(negedge clk);
      check({8'h00, sr1}, 16'h0000);
      wr(24'h018000);
      wp_n = 1'b0;
      wr(24'h018c00);
      check({13'h0, sr1.block_protect_bits}, 16'h0000);
      wp_n = 1'b1;
      wr(24'h018400);
      check({8'h00, sr1}, 16'h0084);
      wr(24'h018002);
      wp_n = 1'b0;
      wr(24'h018c02);
      check({13'h0, sr1.block_protect_bits}, 16'h0003);
      // Frame of 12 data bits is discarded
      host.xfer(24'h060000, 8, rx);
      host.xfer(24'h011c02, 20, rx);
      repeat (30) @(negedge clk);
      check({13'h0, sr1.block_protect_bits}, 16'h0003);
      fail = 1'b1;
      wr(24'h018c02);
      fail = 1'b0;
      check({15'h0, sr1.program_error}, 16'h0001);
      host.xfer(24'hb90000, 8, rx);
      host.xfer(24'h01ffff, 24, rx);
      check({8'h00, bank}, 16'h0003);
      ebusy = 1'b1;
      host.xfer(24'h170500, 16, rx);
      check({bank, 1'b0, upper}, 16'h0505);
      check({sr1.program_error, sr1.write_in_progress}, 2'b11);
      // Output enable seen high in the data phase, low after
      fork
         host.xfer(24'h050000, 16, rx);
         begin
            repeat (60) @(negedge clk);
            check({15'h0, oe}, 16'h0001);
         end
      join
      check({15'h0, rx[0]}, 16'h0001);
      check({15'h0, oe}, 16'h0000);
      host.xfer(24'h178100, 16, rx);
      check({four, upper}, 16'h0080);
      ebusy = 1'b0;
      // Mid-run reset returns registers to zero
      @(negedge clk) rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check({sr1, cfg}, 16'h0000);
      check({oe, 7'h0, bank}, 16'h0000);
      host.xfer(24'h160000, 16, rx);
      check(rx & 16'h00ff, 16'h0000);
      conclude();
   end
endmodule
